//--- verilog/hlms_top.sv
// hlms_top: picks the host link for in-band traffic, serial or sideband.
// assumes the serial word clock runs during rst_n; sideband pins are
// open drain with pull-ups outside; the far end is the integrated MAC.
//
// Notes on behaviour
// - sideband clock runs at 100, 400, 1000 kHz; the code's bit is 4*(quarter+1) reference cycles, about 99, 385, 909 kHz
// - platform asleep: sideband active, serial powered down
// - sideband carries configuration and in-band messages
// - gigabit operation uses serial link for everything
// - link choice follows platform power state automatically
// - active, phy powered down: serial electrical idle
// - active, ethernet idle or unplugged: serial idle
// - active, ethernet in low power idle: idle
// - fully active platform: serial link active
// - platform reset rising moves traffic to serial
// - reset assertion discards unfinished packets
// - unacknowledged sideband messages resent on serial
// - platform reset falling moves traffic to sideband
// - reset falling discards unfinished serial packets
// - unacknowledged serial messages resent on sideband
// - changeover handshake runs over the sideband
// - serial link off while platform sleeps
`timescale 1ns/1ps
`default_nettype none

module hlms_top #(
  parameter int MSG_COUNT = 4,
  parameter int ID_W = 2
) (
  // clocks and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // platform
  input wire logic platform_reset_n,
  // phy core status and sideband rate select
  input wire logic phy_power_down,
  input wire logic eth_link_up,
  input wire logic eth_link_idle,
  input wire logic eth_link_lpi,
  input wire logic [1:0] sideband_rate,
  // in-band messages from the core
  input wire logic msg_valid,
  input wire logic [ID_W-1:0] msg_id,
  input wire logic [7:0] msg_data,
  output logic [MSG_COUNT-1:0] msg_pending,
  output logic msg_acked,
  output logic [ID_W-1:0] msg_acked_id,
  output logic pkt_discard,
  // link state
  output logic sideband_active,
  output logic serial_power_down,
  output logic serial_elec_idle,
  // sideband pins
  input wire logic sideband_clock_pin_in,
  output logic sideband_clock_pin_out,
  output logic sideband_clock_pin_oe,
  input wire logic sideband_data_pin_in,
  output logic sideband_data_pin_out,
  output logic sideband_data_pin_oe,
  // serial link, link_clk domain
  output logic serial_link_enable,
  output logic serial_tx_valid,
  output logic [ID_W-1:0] serial_tx_id,
  output logic [7:0] serial_tx_data,
  input wire logic serial_tx_ready,
  input wire logic serial_ack_valid,
  input wire logic [ID_W-1:0] serial_ack_id,
  output logic serial_ack_ready
);

  hlms_pkg::hlms_mode_type mode;
  hlms_pkg::hlms_sb_state_type sb_state;

  logic plat_s1, plat_s2, plat_s3;
  logic scl_s1, scl_s2, sda_s1, sda_s2;
  logic [MSG_COUNT-1:0] pending, sent, ack_hit;
  logic [7:0] store [MSG_COUNT];
  logic notice_issued, notice_done, clear_sent;
  logic pick_valid;
  logic [ID_W-1:0] pick_id;
  // sideband engine
  logic [hlms_pkg::QTR_W-1:0] q_cnt, quarter, next_quarter;
  logic [1:0] phase;
  logic [4:0] bit_idx;
  logic [hlms_pkg::FRAME_BITS-1:0] shift;
  logic [1:0] acks;
  logic frame_notice, sb_done, sb_step, sb_go_msg, sb_go_notice, sb_ack_evt;
  logic [ID_W-1:0] frame_id;
  // serial crossing, reference side
  logic req_tgl, done_s1, done_s2, ser_idle, ser_go, ser_enable;
  logic [ID_W-1:0] req_id;
  logic [7:0] req_data;
  logic ack_s1, ack_s2, ack_s3, ser_ack_evt;
  // serial crossing, link side
  logic lrst_s1, lrst_s2, en_s1, en_s2;
  logic rq_s1, rq_s2, rq_s3, done_tgl;
  logic ack_tgl, echo_s1, echo_s2;
  logic [ID_W-1:0] ack_id_held;

  // platform reset and sideband pins pass two flops first
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      plat_s1 <= 1'b0;
      plat_s2 <= 1'b0;
      plat_s3 <= 1'b0;
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end
    else
    begin
      plat_s1 <= platform_reset_n;
      plat_s2 <= plat_s1;
      plat_s3 <= plat_s2;
      scl_s1 <= sideband_clock_pin_in;
      scl_s2 <= scl_s1;
      sda_s1 <= sideband_data_pin_in;
      sda_s2 <= sda_s1;
    end
  end

  // lowest pending entry not yet sent on the current link
  always_comb
  begin
    pick_valid = 1'b0;
    pick_id = '0;
    for (int i = MSG_COUNT - 1; i >= 0; i--)
    begin
      if (pending[i] && !sent[i])
      begin
        pick_valid = 1'b1;
        pick_id = ID_W'(i);
      end
    end
  end

  assign ser_idle = (req_tgl == done_s2);
  assign ser_ack_evt = (ack_s2 != ack_s3);
  assign sb_go_msg = (mode == hlms_pkg::MODE_SIDEBAND) && (sb_state == hlms_pkg::SB_IDLE)
    && pick_valid && !sb_done;
  assign sb_go_notice = ((mode == hlms_pkg::MODE_TO_SERIAL)
    || (mode == hlms_pkg::MODE_TO_SIDEBAND))
    && (sb_state == hlms_pkg::SB_IDLE) && !notice_issued && !sb_done;
  assign ser_go = (mode == hlms_pkg::MODE_SERIAL) && ser_idle && pick_valid;
  // a frame's result counts only if the sideband is still the live link
  assign sb_ack_evt = sb_done && !frame_notice && (acks == 2'b00)
    && (mode == hlms_pkg::MODE_SIDEBAND);
  assign clear_sent = ((mode == hlms_pkg::MODE_TO_SERIAL)
    || (mode == hlms_pkg::MODE_TO_SIDEBAND)) && notice_done && ser_idle;

  // mode follows the synchronised platform reset level
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mode <= hlms_pkg::MODE_SIDEBAND;
      notice_issued <= 1'b0;
      notice_done <= 1'b0;
    end
    else
    begin
      case (mode)
        hlms_pkg::MODE_SIDEBAND:
          if (plat_s2)
            mode <= hlms_pkg::MODE_TO_SERIAL;
        hlms_pkg::MODE_TO_SERIAL:
          if (clear_sent)
            mode <= hlms_pkg::MODE_SERIAL;
        hlms_pkg::MODE_SERIAL:
          if (!plat_s2)
            mode <= hlms_pkg::MODE_TO_SIDEBAND;
        hlms_pkg::MODE_TO_SIDEBAND:
          if (clear_sent)
            mode <= hlms_pkg::MODE_SIDEBAND;
        default:
          mode <= hlms_pkg::MODE_SIDEBAND;
      endcase
      if (clear_sent)
      begin
        notice_issued <= 1'b0;
        notice_done <= 1'b0;
      end
      else
      begin
        if (sb_go_notice)
          notice_issued <= 1'b1;
        if (sb_done && frame_notice)
          notice_done <= 1'b1;
      end
    end
  end

  // link state outputs and packet discard on each platform edge
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pkt_discard <= 1'b0;
      sideband_active <= 1'b1;
      serial_power_down <= 1'b1;
      serial_elec_idle <= 1'b0;
      ser_enable <= 1'b0;
    end
    else
    begin
      pkt_discard <= (plat_s2 != plat_s3);
      sideband_active <= (mode != hlms_pkg::MODE_SERIAL);
      serial_power_down <= !plat_s2;
      serial_elec_idle <= plat_s2 && (phy_power_down || !eth_link_up
        || eth_link_idle || eth_link_lpi);
      ser_enable <= (mode == hlms_pkg::MODE_SERIAL);
    end
  end

  // per-entry message store, pending and sent flags
  generate
    for (genvar i = 0; i < MSG_COUNT; i++)
    begin : g_entry
      logic hit_new;
      assign hit_new = msg_valid && (msg_id == ID_W'(i));
      assign ack_hit[i] = (ser_ack_evt && (ack_id_held == ID_W'(i)))
        || (sb_ack_evt && (frame_id == ID_W'(i)));
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          pending[i] <= 1'b0;
          sent[i] <= 1'b0;
          store[i] <= 8'h00;
        end
        else
        begin
          if (hit_new)
          begin
            pending[i] <= 1'b1;
            store[i] <= msg_data;
          end
          else if (ack_hit[i])
            pending[i] <= 1'b0;
          if (clear_sent || hit_new)
            sent[i] <= 1'b0;
          else if ((sb_go_msg || ser_go) && (pick_id == ID_W'(i)))
            sent[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // acknowledge report to the core
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      msg_pending <= '0;
      msg_acked <= 1'b0;
      msg_acked_id <= '0;
    end
    else
    begin
      msg_pending <= pending;
      msg_acked <= ser_ack_evt || sb_ack_evt;
      msg_acked_id <= ser_ack_evt ? ack_id_held : frame_id;
    end
  end

  // quarter-bit length for the selected bus rate
  always_comb
  begin
    case (sideband_rate)
      hlms_pkg::SB_RATE_400K: next_quarter = hlms_pkg::SB_QTR_400K;
      hlms_pkg::SB_RATE_1000K: next_quarter = hlms_pkg::SB_QTR_1000K;
      default: next_quarter = hlms_pkg::SB_QTR_100K;
    endcase
  end

  // stall while the far end stretches the clock low
  assign sb_step = (q_cnt == '0) && !((phase == 2'h2) && !scl_s2);

  // sideband frame engine: start, 18 bits, stop
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sb_state <= hlms_pkg::SB_IDLE;
      q_cnt <= '0;
      quarter <= hlms_pkg::SB_QTR_100K;
      phase <= 2'h0;
      bit_idx <= 5'h00;
      shift <= '0;
      acks <= 2'h3;
      frame_notice <= 1'b0;
      frame_id <= '0;
      sb_done <= 1'b0;
      sideband_clock_pin_oe <= 1'b0;
      sideband_data_pin_oe <= 1'b0;
    end
    else
    begin
      sb_done <= 1'b0;
      if (q_cnt != '0)
        q_cnt <= q_cnt - 1'b1;
      else if (sb_step)
        q_cnt <= quarter;
      case (sb_state)
        hlms_pkg::SB_IDLE:
          if (sb_go_msg || sb_go_notice)
          begin
            sb_state <= hlms_pkg::SB_START;
            quarter <= next_quarter;
            q_cnt <= next_quarter;
            phase <= 2'h0;
            bit_idx <= 5'h00;
            acks <= 2'h3;
            frame_notice <= sb_go_notice;
            frame_id <= sb_go_notice ? '0 : pick_id;
            if (sb_go_notice)
              shift <= {1'b1, 7'h00, 1'b1, (mode == hlms_pkg::MODE_TO_SERIAL)
                ? hlms_pkg::NOTICE_TO_SERIAL : hlms_pkg::NOTICE_TO_SIDEBAND, 1'b1};
            else
              shift <= {1'b0, 7'(pick_id), 1'b1, store[pick_id], 1'b1};
          end
        hlms_pkg::SB_START:
          if (sb_step)
          begin
            if (phase == 2'h0)
            begin
              sideband_data_pin_oe <= 1'b1;
              phase <= 2'h1;
            end
            else
            begin
              sideband_clock_pin_oe <= 1'b1;
              phase <= 2'h0;
              sb_state <= hlms_pkg::SB_BITS;
            end
          end
        hlms_pkg::SB_BITS:
          if (sb_step)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sideband_data_pin_oe <= !shift[hlms_pkg::FRAME_BITS-1];
              2'h1: sideband_clock_pin_oe <= 1'b0;
              2'h2:
              begin
                if (bit_idx == hlms_pkg::ACK_BIT_FIRST)
                  acks[0] <= sda_s2;
                if (bit_idx == hlms_pkg::ACK_BIT_LAST)
                  acks[1] <= sda_s2;
              end
              default:
              begin
                sideband_clock_pin_oe <= 1'b1;
                shift <= {shift[hlms_pkg::FRAME_BITS-2:0], 1'b1};
                if (bit_idx == hlms_pkg::ACK_BIT_LAST)
                  sb_state <= hlms_pkg::SB_STOP;
                else
                  bit_idx <= bit_idx + 5'h01;
              end
            endcase
          end
        hlms_pkg::SB_STOP:
          if (sb_step)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sideband_data_pin_oe <= 1'b1;
              2'h1: sideband_clock_pin_oe <= 1'b0;
              2'h2: sideband_data_pin_oe <= 1'b0;
              default:
              begin
                sb_state <= hlms_pkg::SB_IDLE;
                sb_done <= 1'b1;
              end
            endcase
          end
        default:
          sb_state <= hlms_pkg::SB_IDLE;
      endcase
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sideband_clock_pin_out <= 1'b0;
      sideband_data_pin_out <= 1'b0;
    end
    else
    begin
      sideband_clock_pin_out <= 1'b0;
      sideband_data_pin_out <= 1'b0;
    end
  end

  // serial request toggle and returning acknowledge, reference side
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      req_tgl <= 1'b0;
      req_id <= '0;
      req_data <= 8'h00;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
    end
    else
    begin
      done_s1 <= done_tgl;
      done_s2 <= done_s1;
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      if (ser_go)
      begin
        req_tgl <= !req_tgl;
        req_id <= pick_id;
        req_data <= store[pick_id];
      end
    end
  end

  // link-side reset synchroniser
  always_ff @(posedge link_clk)
  begin
    lrst_s1 <= rst_n;
    lrst_s2 <= lrst_s1;
  end

  // serial link logic, link_clk domain
  always_ff @(posedge link_clk)
  begin
    if (!lrst_s2)
    begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      serial_link_enable <= 1'b0;
      rq_s1 <= 1'b0;
      rq_s2 <= 1'b0;
      rq_s3 <= 1'b0;
      done_tgl <= 1'b0;
      serial_tx_valid <= 1'b0;
      serial_tx_id <= '0;
      serial_tx_data <= 8'h00;
    end
    else
    begin
      en_s1 <= ser_enable;
      en_s2 <= en_s1;
      serial_link_enable <= en_s2;
      rq_s1 <= req_tgl;
      rq_s2 <= rq_s1;
      rq_s3 <= rq_s2;
      if (rq_s2 != rq_s3)
      begin
        serial_tx_valid <= 1'b1;
        serial_tx_id <= req_id;
        serial_tx_data <= req_data;
      end
      else if (serial_tx_valid && (serial_tx_ready || !en_s2))
      begin
        serial_tx_valid <= 1'b0;
        done_tgl <= !done_tgl;
      end
    end
  end

  // acknowledge capture, held until the reference side echoes it
  always_ff @(posedge link_clk)
  begin
    if (!lrst_s2)
    begin
      echo_s1 <= 1'b0;
      echo_s2 <= 1'b0;
      ack_tgl <= 1'b0;
      ack_id_held <= '0;
      serial_ack_ready <= 1'b0;
    end
    else
    begin
      echo_s1 <= ack_s3;
      echo_s2 <= echo_s1;
      if (serial_ack_valid && serial_ack_ready)
      begin
        ack_tgl <= !ack_tgl;
        ack_id_held <= serial_ack_id;
        serial_ack_ready <= 1'b0;
      end
      else
        serial_ack_ready <= (ack_tgl == echo_s2);
    end
  end

endmodule // hlms_top
`default_nettype wire

//--- pkg/hlms_pkg.sv
// hlms_pkg: constants and types for the host link mode switch.
// assumes a 40 MHz reference clock; sideband timing derives from it.
package hlms_pkg;

  localparam int REF_CLK_PERIOD_NS = 25;

  // sideband bus clock periods, one per supported rate
  localparam int SB_PERIOD_100K_NS = 10000;
  localparam int SB_PERIOD_400K_NS = 2500;
  localparam int SB_PERIOD_1000K_NS = 1000;

  // quarter-bit reload values; a quarter lasts this many reference cycles plus one
  localparam int QTR_W = 8;
  localparam logic [QTR_W-1:0] SB_QTR_100K =
    QTR_W'(SB_PERIOD_100K_NS / (4 * REF_CLK_PERIOD_NS));
  localparam logic [QTR_W-1:0] SB_QTR_400K =
    QTR_W'(SB_PERIOD_400K_NS / (4 * REF_CLK_PERIOD_NS));
  localparam logic [QTR_W-1:0] SB_QTR_1000K =
    QTR_W'(SB_PERIOD_1000K_NS / (4 * REF_CLK_PERIOD_NS));

  // rate select codes
  localparam logic [1:0] SB_RATE_100K = 2'h0;
  localparam logic [1:0] SB_RATE_400K = 2'h1;
  localparam logic [1:0] SB_RATE_1000K = 2'h2;

  // sideband frame: tag byte, ack slot, payload byte, ack slot
  localparam int FRAME_BITS = 18;
  localparam logic [4:0] ACK_BIT_FIRST = 5'h08;
  localparam logic [4:0] ACK_BIT_LAST = 5'h11;

  // changeover notice payloads
  localparam logic [7:0] NOTICE_TO_SERIAL = 8'h01;
  localparam logic [7:0] NOTICE_TO_SIDEBAND = 8'h02;

  typedef enum logic [3:0] {
    MODE_SIDEBAND = 4'h1,
    MODE_TO_SERIAL = 4'h2,
    MODE_SERIAL = 4'h4,
    MODE_TO_SIDEBAND = 4'h8
  } hlms_mode_type;

  typedef enum logic [3:0] {
    SB_IDLE = 4'h1,
    SB_START = 4'h2,
    SB_BITS = 4'h4,
    SB_STOP = 4'h8
  } hlms_sb_state_type;

endpackage

//--- dv/hlms_top_sva.sv
// hlms_top_sva: port checks for the host link mode switch.
// assumes a bind into hlms_top; inputs change away from ref_clk edges.
`timescale 1ns/1ps
`default_nettype none
module hlms_top_sva #(
  parameter int MSG_COUNT = 4,
  parameter int ID_W = 2
) (
  // clocks and reset
  input wire logic ref_clk,
  input wire logic link_clk,
  input wire logic rst_n,
  // platform and core status
  input wire logic platform_reset_n,
  input wire logic phy_power_down,
  input wire logic eth_link_up,
  input wire logic eth_link_idle,
  input wire logic eth_link_lpi,
  // messages
  input wire logic msg_valid,
  input wire logic [ID_W-1:0] msg_id,
  input wire logic [MSG_COUNT-1:0] msg_pending,
  input wire logic msg_acked,
  input wire logic pkt_discard,
  // link state
  input wire logic sideband_active,
  input wire logic serial_power_down,
  input wire logic serial_elec_idle,
  // serial transmit
  input wire logic serial_link_enable,
  input wire logic serial_tx_valid,
  input wire logic [ID_W-1:0] serial_tx_id,
  input wire logic serial_tx_ready
);
  logic [2:0] ack_hist;

  // recent acks, so a pending drop can be traced
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      ack_hist <= 3'h0;
    else
      ack_hist <= {ack_hist[1:0], msg_acked};
  end

  a_power_follows_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(platform_reset_n) |-> ##[2:3] (serial_power_down == !platform_reset_n))
    else $error("power down late");
  a_discard_on_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(platform_reset_n) |-> ##[2:3] pkt_discard)
    else $error("no discard pulse");
  a_sleep_uses_sideband: assert property (@(posedge ref_clk) disable iff (!rst_n)
    serial_power_down [*3] |-> sideband_active && !serial_elec_idle)
    else $error("sleep link state wrong");
  a_idle_power_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (platform_reset_n && phy_power_down) [*4] |=> serial_elec_idle)
    else $error("no idle at power down");
  a_idle_no_link: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (platform_reset_n && (!eth_link_up || eth_link_idle)) [*4] |=> serial_elec_idle)
    else $error("no idle without link");
  a_idle_low_power: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (platform_reset_n && eth_link_lpi) [*4] |=> serial_elec_idle)
    else $error("no idle in low power");
  a_active_serial: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (platform_reset_n && eth_link_up && !phy_power_down && !eth_link_idle
      && !eth_link_lpi) [*4] |=> !serial_elec_idle)
    else $error("serial idle while active");
  a_pending_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    msg_valid |-> ##2 msg_pending[$past(msg_id, 2)])
    else $error("pending not set");
  a_pending_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (($past(msg_pending) & ~msg_pending) != '0) |-> (ack_hist != 3'h0 || msg_acked)
      or ##1 msg_acked)
    else $error("pending dropped without ack");
  a_tx_held: assert property (@(posedge link_clk) disable iff (!rst_n)
    serial_tx_valid && !serial_tx_ready && serial_link_enable |=>
      !serial_link_enable || (serial_tx_valid && $stable(serial_tx_id)))
    else $error("serial message withdrawn");

  c_discard: cover property (@(posedge ref_clk) pkt_discard);
  c_acked: cover property (@(posedge ref_clk) msg_acked);
  c_serial_tx: cover property (@(posedge link_clk) serial_tx_valid && serial_tx_ready);
endmodule // hlms_top_sva

bind hlms_top hlms_top_sva #(.MSG_COUNT(MSG_COUNT), .ID_W(ID_W)) u_sva (
  .ref_clk(ref_clk), .link_clk(link_clk), .rst_n(rst_n),
  .platform_reset_n(platform_reset_n), .phy_power_down(phy_power_down),
  .eth_link_up(eth_link_up), .eth_link_idle(eth_link_idle), .eth_link_lpi(eth_link_lpi),
  .msg_valid(msg_valid), .msg_id(msg_id), .msg_pending(msg_pending),
  .msg_acked(msg_acked), .pkt_discard(pkt_discard), .sideband_active(sideband_active),
  .serial_power_down(serial_power_down), .serial_elec_idle(serial_elec_idle),
  .serial_link_enable(serial_link_enable), .serial_tx_valid(serial_tx_valid),
  .serial_tx_id(serial_tx_id), .serial_tx_ready(serial_tx_ready)
);
`default_nettype wire

//--- dv/hlms_mac_model.sv
// hlms_mac_model: stand-in for the integrated MAC on both host links.
// assumes resolved open-drain sideband wires and a running link_clk.
`timescale 1ns/1ps
`default_nettype none
module hlms_mac_model #(
  parameter int ID_W = 2
) (
  // clock, reset and misbehaviour controls
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic nack,
  input wire logic drop,
  // sideband wires
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  // serial link
  input wire logic tx_valid,
  input wire logic [ID_W-1:0] tx_id,
  output logic tx_ready,
  output logic ack_valid,
  output logic [ID_W-1:0] ack_id,
  input wire logic ack_ready
);
  int bits;
  logic [17:0] frame;

  // ready one cycle late, so the design must hold its request
  always_ff @(posedge link_clk)
  begin
    if (!rst_n)
      tx_ready <= 1'b0;
    else
      tx_ready <= tx_valid && !tx_ready;
  end
  initial sda_oe = 1'b0;
  // start condition restarts the bit count
  always @(negedge sda)
  begin
    if (scl)
      bits = 0;
  end
  // keep the bits of the last frame as received
  always @(posedge scl)
  begin
    bits = bits + 1;
    if (bits <= 18)
      frame = {frame[16:0], sda};
  end
  // sole responder on the bus: pull data low in both ack slots
  always @(negedge scl)
  begin
    sda_oe = !nack && (bits == int'(hlms_pkg::ACK_BIT_FIRST)
      || bits == int'(hlms_pkg::ACK_BIT_LAST));
  end
  always_ff @(posedge link_clk)
  begin
    if (!rst_n)
      ack_valid <= 1'b0;
    else if (tx_valid && tx_ready && !drop)
      ack_valid <= 1'b1;
    else if (ack_ready)
      ack_valid <= 1'b0;
  end
  // id shows its inverse once the ack is taken
  always_ff @(posedge link_clk)
  begin
    if (!rst_n)
      ack_id <= '0;
    else if (tx_valid && tx_ready)
      ack_id <= tx_id;
    else if (ack_valid && ack_ready)
      ack_id <= ~ack_id;
  end
endmodule // hlms_mac_model
`default_nettype wire

//--- dv/hlms_top_tb.sv
// hlms_top_tb: self-checking bench for the host link mode switch.
// assumes hlms_mac_model at the far side and pull-ups on both pins.
`timescale 1ns/1ps
`default_nettype none
module hlms_top_tb;
  logic ref_clk, link_clk, rst_n, plat_n, pd, up, idle, lpi, mv, nack, drop;
  logic [1:0] rate, mid, aid, tid, cid;
  logic [7:0] mdat, tdat;
  logic [3:0] pend;
  logic acked, disc, sb_act, spd, eidle, en, tv, tr, cv, cr, scl_oe, sda_oe, m_oe;
  logic scl_o, sda_o;
  wire logic scl, sda;
  int miscompares, checks, cyc;

  assign scl = !scl_oe;
  assign sda = !(sda_oe || m_oe);
  hlms_top #(.MSG_COUNT(4), .ID_W(2)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
    .platform_reset_n(plat_n), .phy_power_down(pd), .eth_link_up(up),
    .eth_link_idle(idle), .eth_link_lpi(lpi), .sideband_rate(rate),
    .msg_valid(mv), .msg_id(mid), .msg_data(mdat), .msg_pending(pend),
    .msg_acked(acked), .msg_acked_id(aid), .pkt_discard(disc),
    .sideband_active(sb_act), .serial_power_down(spd), .serial_elec_idle(eidle),
    .sideband_clock_pin_in(scl), .sideband_clock_pin_out(scl_o),
    .sideband_clock_pin_oe(scl_oe), .sideband_data_pin_in(sda),
    .sideband_data_pin_out(sda_o), .sideband_data_pin_oe(sda_oe),
    .serial_link_enable(en), .serial_tx_valid(tv), .serial_tx_id(tid),
    .serial_tx_data(tdat), .serial_tx_ready(tr), .serial_ack_valid(cv),
    .serial_ack_id(cid), .serial_ack_ready(cr)
  );
  hlms_mac_model #(.ID_W(2)) u_mac (
    .link_clk(link_clk), .rst_n(rst_n), .nack(nack), .drop(drop), .scl(scl),
    .sda(sda), .sda_oe(m_oe), .tx_valid(tv), .tx_id(tid), .tx_ready(tr),
    .ack_valid(cv), .ack_id(cid), .ack_ready(cr)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = !ref_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = !link_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      miscompares = miscompares + 1;
      complete_run;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic send(input logic [1:0] id, input logic [7:0] data);
    @(negedge ref_clk);
    mv = 1'b1;
    mid = id;
    mdat = data;
    @(negedge ref_clk);
    mv = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(16'(pend[id]), 16'h1);
  endtask

  task automatic wait_ack(input logic [1:0] id, input int lim, input logic exp);
    logic hit;
    hit = 1'b0;
    while (!hit && lim > 0)
    begin
      @(negedge ref_clk);
      hit = (acked === 1'b1);
      lim = lim - 1;
    end
    chk(16'(hit), 16'(exp));
    if (exp)
      chk(16'(aid), 16'(id));
  endtask

  task automatic set_plat(input logic v);
    logic hit;
    hit = 1'b0;
    @(negedge ref_clk);
    plat_n = v;
    repeat (4)
    begin
      @(negedge ref_clk);
      hit = hit || (disc === 1'b1);
    end
    chk(16'(hit), 16'h1);
    chk(16'(spd), 16'(!v));
  endtask

  task automatic t_reset;
    chk(16'(sb_act), 16'h1);
    chk(16'(spd), 16'h1);
    chk(16'(en), 16'h0);
    chk(16'(pend), 16'h0);
  endtask

  task automatic t_rates;
    logic [7:0] q [3];
    time t0;
    q = '{hlms_pkg::SB_QTR_100K, hlms_pkg::SB_QTR_400K, hlms_pkg::SB_QTR_1000K};
    for (int r = 0; r < 3; r++)
    begin
      rate = 2'(r);
      send(2'(r), 8'ha5);
      @(posedge scl);
      t0 = $time;
      @(posedge scl);
      chk(16'(($time - t0) / 25), 16'(4 * (q[r] + 1)));
      wait_ack(2'(r), 12000, 1'b1);
      repeat (2) @(negedge ref_clk);
      chk(16'(pend[r]), 16'h0);
      chk(16'(tv), 16'h0);
      chk(16'(u_mac.frame[17:10]), 16'(r));
      chk(16'(u_mac.frame[8:1]), 16'ha5);
      chk(16'({scl_o, sda_o}), 16'h0);
    end
  endtask

  task automatic t_to_serial;
    nack = 1'b1;
    send(2'h2, 8'h5a);
    wait_ack(2'h2, 1500, 1'b0);
    chk(16'(pend[2]), 16'h1);
    nack = 1'b0;
    set_plat(1'b1);
    wait_ack(2'h2, 5000, 1'b1);
    chk(16'(sb_act), 16'h0);
    chk(16'(en), 16'h1);
    chk(16'(tid), 16'h2);
    chk(16'(tdat), 16'h5a);
    chk(16'(u_mac.frame[17:10]), 16'h80);
    chk(16'(u_mac.frame[8:1]), 16'(hlms_pkg::NOTICE_TO_SERIAL));
  endtask

  task automatic t_idle_table;
    logic [4:0] tbl [5];
    tbl = '{5'h08, 5'h19, 5'h01, 5'h0d, 5'h0b};
    foreach (tbl[i])
    begin
      {pd, up, idle, lpi} = tbl[i][4:1];
      repeat (4) @(negedge ref_clk);
      chk(16'(eidle), 16'(tbl[i][0]));
    end
    {pd, up, idle, lpi} = 4'h4;
  endtask

  task automatic t_to_sideband;
    send(2'h1, 8'h33);
    wait_ack(2'h1, 600, 1'b1);
    chk(16'(tid), 16'h1);
    chk(16'(tdat), 16'h33);
    drop = 1'b1;
    send(2'h3, 8'h77);
    wait_ack(2'h3, 300, 1'b0);
    drop = 1'b0;
    set_plat(1'b0);
    chk(16'(sb_act), 16'h1);
    wait_ack(2'h3, 5000, 1'b1);
    chk(16'(tv), 16'h0);
    chk(16'(u_mac.frame[17:10]), 16'h3);
    chk(16'(u_mac.frame[8:1]), 16'h77);
  endtask

  initial
  begin
    rst_n = 1'b0;
    plat_n = 1'b0;
    {pd, up, idle, lpi} = 4'h4;
    mv = 1'b0;
    mid = 2'h0;
    mdat = 8'h00;
    nack = 1'b0;
    drop = 1'b0;
    rate = 2'h2;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    // link side leaves reset through its own synchroniser a few edges later
    repeat (24) @(negedge ref_clk);
    t_reset;
    t_rates;
    t_to_serial;
    t_idle_table;
    t_to_sideband;
    complete_run;
  end
endmodule // hlms_top_tb
`default_nettype wire
